// ---- hpu_defines.vh ----
// constants for the host parameter and patch upload register bank
// assumes an 8-bit register address/data port from the host serial slave
// Function
// R1 - six host-written extension bytes, core readable
// R2 - seven more extension bytes, same behaviour
// R3 - eight-byte staging area for parameter writes
// R4 - each sensor record spans eight bytes
// R5 - command bit 7 picks read or write
// R6 - command bits 6..0 pick the page
// R7 - host clears acknowledge before next request
// R8 - read-only code version word, zero if absent
// R9 - read-only patch version word, zero if none
// R10 - read-only part number byte
// R11 - read-only silicon step byte
// R12 - patch pointer resets zero, host rezeroes it
// R13 - patch pointer stored high byte first
// R14 - stream port takes image bytes in order
// R15 - host skips header, swaps each word
// R16 - read-only 32-bit checksum over streamed data
// R17 - host leaves upload mode after checksum match
// R18 - restart trigger pulses reset, self clears
// R19 - mailbox handshake guards shared transfer registers; code gates only param_req_pulse, stage and command writes pass regardless
// R20 - pages one to three: system, algorithm, sensors
// R21 - writes to read-only registers are ignored
`ifndef HPU_DEFINES_VH
`define HPU_DEFINES_VH
// ==========================================
// register offsets
`define HPU_EXT_A_LO      8'h56
`define HPU_EXT_A_HI      8'h5b
`define HPU_STAGE_LO      8'h5c
`define HPU_STAGE_HI      8'h63
`define HPU_XFER_CMD      8'h64
`define HPU_EXT_B_LO      8'h65
`define HPU_EXT_B_HI      8'h6b
`define HPU_CODE_VER_HI   8'h70
`define HPU_CODE_VER_LO   8'h71
`define HPU_PATCH_VER_HI  8'h72
`define HPU_PATCH_VER_LO  8'h73
`define HPU_PART_NUM      8'h90
`define HPU_SI_STEP       8'h91
`define HPU_PTR_HI        8'h94
`define HPU_PTR_LO        8'h95
`define HPU_STREAM        8'h96
`define HPU_CRC_B0        8'h97
`define HPU_CRC_B3        8'h9a
`define HPU_RESTART       8'h9b
// ==========================================
// fields and reset values
`define HPU_CMD_DIR_BIT   7
`define HPU_REC_BYTES     8
`define HPU_PTR_RESET     16'h0000
`define HPU_CRC_SEED      32'hffff_ffff
`define HPU_CRC_POLY      32'hedb8_8320
`define HPU_PAGE_SYSTEM   7'h01
`define HPU_PAGE_ALGO     7'h02
`define HPU_PAGE_SENSORS  7'h03
`endif

// ---- hpu_crc32.v ----
// byte-wise reflected crc32 accumulator for the patch stream
// assumes one byte strobe per cycle at most
`include "hpu_defines.vh"
module hpu_crc32 (
  sys_clk,
  reset_n,
  crc_clear,
  byte_valid,
  byte_data,
  crc_value
);
  input             sys_clk;
  input             reset_n;
  input             crc_clear;
  input             byte_valid;
  input      [7:0]  byte_data;
  output     [31:0] crc_value;

  reg  [31:0] crc_reg;
  reg  [31:0] crc_next;
  integer     i;

  // ==========================================
  // eight serial steps per byte
  always @* begin
    crc_next = crc_reg ^ {24'h00_0000, byte_data};
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_next[0])
        crc_next = (crc_next >> 1) ^ `HPU_CRC_POLY;
      else
        crc_next = crc_next >> 1;
    end
  end

  // seed on clear, accumulate on each byte
  always @(posedge sys_clk) begin
    if (!reset_n || crc_clear)
      crc_reg <= `HPU_CRC_SEED;
    else if (byte_valid)
      crc_reg <= crc_next; // see R16
  end

  assign crc_value = ~crc_reg;
endmodule

// ---- hpu_regs.v ----
// host parameter and patch upload register bank
// assumes host slave presents single-cycle byte read/write strobes
`include "hpu_defines.vh"
module hpu_regs #(
  parameter [15:0] CODE_VERSION  = 16'h0000, // arbitrary
  parameter [7:0]  PART_NUMBER   = 8'h5a,    // arbitrary
  parameter [7:0]  SILICON_STEP  = 8'h0a     // arbitrary
) (
  sys_clk,
  reset_n,
  host_addr,
  host_wr,
  host_wdata,
  host_rd,
  host_rdata,
  upload_enable,
  patch_version,
  core_addr,
  core_rdata,
  param_req_pulse,
  param_req_dir,
  param_req_page,
  param_ack_zero,
  patch_wr_valid,
  patch_wr_addr,
  patch_wr_data,
  cpu_reset_pulse
);
  input             sys_clk;
  input             reset_n;
  input      [7:0]  host_addr;
  input             host_wr;
  input      [7:0]  host_wdata;
  input             host_rd;
  output reg [7:0]  host_rdata;
  input             upload_enable;
  input      [15:0] patch_version;
  input      [3:0]  core_addr;
  output reg [7:0]  core_rdata;
  output reg        param_req_pulse;
  output reg        param_req_dir;
  output reg [6:0]  param_req_page;
  input             param_ack_zero;
  output reg        patch_wr_valid;
  output reg [15:0] patch_wr_addr;
  output reg [7:0]  patch_wr_data;
  output reg        cpu_reset_pulse;

  // extension bytes: a in 0..5, b in 6..12
  reg  [7:0]  ext_reg [0:12];
  reg  [7:0]  stage_reg [0:`HPU_REC_BYTES-1];
  reg  [7:0]  cmd_reg;
  reg  [15:0] ptr_reg;
  reg  [7:0]  stream_reg;
  reg  [7:0]  restart_reg;
  wire [31:0] crc_value;
  wire        ptr_zero_wr;
  integer     k;

  // ==========================================
  // decode helpers
  function in_range;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  function [3:0] ext_index;
    input [7:0] a;
    reg   [7:0] d;
    begin
      d = 8'h00;
      if (in_range(a, `HPU_EXT_A_LO, `HPU_EXT_A_HI))
        d = a - `HPU_EXT_A_LO;
      else if (in_range(a, `HPU_EXT_B_LO, `HPU_EXT_B_HI))
        d = a - `HPU_EXT_B_LO + 8'h06;
      ext_index = d[3:0];
    end
  endfunction

  wire ext_hit = in_range(host_addr, `HPU_EXT_A_LO, `HPU_EXT_A_HI) ||
                 in_range(host_addr, `HPU_EXT_B_LO, `HPU_EXT_B_HI);
  wire stage_hit = in_range(host_addr, `HPU_STAGE_LO, `HPU_STAGE_HI);
  wire [7:0] stage_off = host_addr - `HPU_STAGE_LO;
  // pointer low byte written zero while high byte is zero
  assign ptr_zero_wr = host_wr && (host_addr == `HPU_PTR_LO) &&
                       (host_wdata == 8'h00) && (ptr_reg[15:8] == 8'h00);

  // ==========================================
  // host writes to read-write registers
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      for (k = 0; k < 13; k = k + 1)
        ext_reg[k] <= 8'h00;
      for (k = 0; k < `HPU_REC_BYTES; k = k + 1)
        stage_reg[k] <= 8'h00;
      cmd_reg     <= 8'h00;
      stream_reg  <= 8'h00;
    end else if (host_wr) begin
      if (ext_hit)
        ext_reg[ext_index(host_addr)] <= host_wdata; // see R1 see R2
      if (stage_hit)
        stage_reg[stage_off[2:0]] <= host_wdata; // see R3 see R4
      if (host_addr == `HPU_XFER_CMD)
        cmd_reg <= host_wdata; // see R5 see R6
      if (host_addr == `HPU_STREAM)
        stream_reg <= host_wdata;
      // read-only addresses fall through untouched, see R21
    end
  end

  // ==========================================
  // parameter request strobe to the core mailbox
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      param_req_pulse <= 1'b0;
      param_req_dir   <= 1'b0;
      param_req_page  <= 7'h00;
    end else begin
      // new request only once acknowledge is back at zero, see R7 see R19
      param_req_pulse <= host_wr && (host_addr == `HPU_XFER_CMD) &&
                         param_ack_zero;
      if (host_wr && (host_addr == `HPU_XFER_CMD)) begin
        param_req_dir  <= host_wdata[`HPU_CMD_DIR_BIT]; // see R5
        param_req_page <= host_wdata[6:0]; // see R6 see R20
      end
    end
  end

  // ==========================================
  // patch pointer, stream and advance
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      ptr_reg        <= `HPU_PTR_RESET; // see R12
      patch_wr_valid <= 1'b0;
      patch_wr_addr  <= 16'h0000;
      patch_wr_data  <= 8'h00;
    end else begin
      patch_wr_valid <= 1'b0;
      if (host_wr && host_addr == `HPU_PTR_HI)
        ptr_reg[15:8] <= host_wdata; // see R13
      else if (host_wr && host_addr == `HPU_PTR_LO)
        ptr_reg[7:0] <= host_wdata; // see R13
      else if (host_wr && host_addr == `HPU_STREAM && upload_enable) begin
        patch_wr_valid <= 1'b1; // see R14
        patch_wr_addr  <= ptr_reg;
        patch_wr_data  <= host_wdata;
        ptr_reg        <= ptr_reg + 16'h0001; // advances by one, ffff wraps to zero, see R12
      end
    end
  end

  // checksum restarts when the pointer low byte is written zero while the high byte is already zero
  hpu_crc32 u_crc (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .crc_clear  (ptr_zero_wr),
    .byte_valid (host_wr && host_addr == `HPU_STREAM && upload_enable),
    .byte_data  (host_wdata),
    .crc_value  (crc_value)
  ); // see R16

  // ==========================================
  // restart trigger self clears after one cycle
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      restart_reg     <= 8'h00;
      cpu_reset_pulse <= 1'b0;
    end else begin
      if (host_wr && host_addr == `HPU_RESTART && host_wdata[0])
        restart_reg <= 8'h01; // see R18
      else
        restart_reg <= 8'h00;
      cpu_reset_pulse <= host_wr && host_addr == `HPU_RESTART &&
                         host_wdata[0]; // see R18
    end
  end

  // ==========================================
  // host read mux
  always @(posedge sys_clk) begin
    if (!reset_n)
      host_rdata <= 8'h00;
    else if (host_rd) begin
      if (ext_hit)
        host_rdata <= ext_reg[ext_index(host_addr)];
      else if (stage_hit)
        host_rdata <= stage_reg[stage_off[2:0]];
      else begin
        case (host_addr)
          `HPU_XFER_CMD:     host_rdata <= cmd_reg;
          `HPU_CODE_VER_HI:  host_rdata <= CODE_VERSION[15:8]; // see R8
          `HPU_CODE_VER_LO:  host_rdata <= CODE_VERSION[7:0];
          `HPU_PATCH_VER_HI: host_rdata <= patch_version[15:8]; // see R9
          `HPU_PATCH_VER_LO: host_rdata <= patch_version[7:0];
          `HPU_PART_NUM:     host_rdata <= PART_NUMBER; // see R10
          `HPU_SI_STEP:      host_rdata <= SILICON_STEP; // see R11
          `HPU_PTR_HI:       host_rdata <= ptr_reg[15:8];
          `HPU_PTR_LO:       host_rdata <= ptr_reg[7:0];
          `HPU_STREAM:       host_rdata <= stream_reg;
          8'h97:             host_rdata <= crc_value[7:0];
          8'h98:             host_rdata <= crc_value[15:8];
          8'h99:             host_rdata <= crc_value[23:16];
          `HPU_CRC_B3:       host_rdata <= crc_value[31:24];
          `HPU_RESTART:      host_rdata <= restart_reg;
          default:           host_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================
  // core side read of extension bytes
  always @(posedge sys_clk) begin
    if (!reset_n)
      core_rdata <= 8'h00;
    else if (core_addr < 4'd13)
      core_rdata <= ext_reg[core_addr]; // see R1 see R2
    else
      core_rdata <= 8'h00;
  end
endmodule

// ---- hpu_core_mdl.sv ----
// patch ram model on the core side of the register bank
// assumes patch writes are one-cycle strobes on sys_clk
module hpu_core_mdl (
  input wire        sys_clk,
  input wire        patch_wr_valid,
  input wire [15:0] patch_wr_addr,
  input wire [7:0]  patch_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:15];
  logic [15:0] last_addr;
  int          n_wr = 0;
  // ====================
  // ram store
  // keep each streamed byte at its address modulo 16
  always @(posedge sys_clk) begin
    if (patch_wr_valid === 1'b1) begin
      mem[patch_wr_addr[3:0]] <= patch_wr_data;
      last_addr <= patch_wr_addr;
      n_wr <= n_wr + 1;
    end
  end
endmodule

// ---- hpu_chk.sv ----
// port checker for the host parameter and patch register bank
// assumes bound to hpu_regs, one clock, sync low reset
module hpu_chk #(
  parameter [7:0] PART_NUMBER  = 8'h5a,
  parameter [7:0] SILICON_STEP = 8'h0a
) (
  input wire        sys_clk,
  input wire        reset_n,
  input wire [7:0]  host_addr,
  input wire        host_wr,
  input wire [7:0]  host_wdata,
  input wire        host_rd,
  input wire [7:0]  host_rdata,
  input wire        upload_enable,
  input wire [15:0] patch_version,
  input wire        param_req_pulse,
  input wire        param_req_dir,
  input wire [6:0]  param_req_page,
  input wire        param_ack_zero,
  input wire        patch_wr_valid,
  input wire [7:0]  patch_wr_data,
  input wire        cpu_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // decoded strobes
  wire cmd_w = host_wr && host_addr == 8'h64;
  wire str_w = host_wr && host_addr == 8'h96 && upload_enable;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ====================
  // properties
  a_req_pulse: assert property (cmd_w && param_ack_zero |=> param_req_pulse)
    else $error("no request pulse");
  a_req_hold: assert property (cmd_w && !param_ack_zero |=> !param_req_pulse)
    else $error("request pulse with ack set");
  a_req_dir: assert property (cmd_w |=> param_req_dir == $past(host_wdata[7]))
    else $error("bad direction");
  a_req_page: assert property (cmd_w |=> param_req_page == $past(host_wdata[6:0]))
    else $error("bad page");
  a_restart_pulse: assert property (host_wr && host_addr == 8'h9b && host_wdata[0]
    |=> cpu_reset_pulse ##1 !cpu_reset_pulse)
    else $error("bad restart pulse");
  a_stream_write: assert property (str_w
    |=> patch_wr_valid && patch_wr_data == $past(host_wdata))
    else $error("stream byte lost");
  a_no_stream: assert property (!str_w |=> !patch_wr_valid)
    else $error("stray ram write");
  a_part_read: assert property (host_rd && host_addr == 8'h90
    |=> host_rdata == PART_NUMBER)
    else $error("bad part code");
  a_patch_ver: assert property (host_rd && host_addr == 8'h72
    |=> host_rdata == $past(patch_version[15:8]))
    else $error("bad patch version");
  c_req: cover property (cmd_w && param_ack_zero);
  c_stream: cover property (str_w);
  c_restart: cover property (cpu_reset_pulse);
endmodule
bind hpu_regs hpu_chk #(.PART_NUMBER(PART_NUMBER),
  .SILICON_STEP(SILICON_STEP)) chk_u (.sys_clk(sys_clk), .reset_n(reset_n),
  .host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata),
  .host_rd(host_rd), .host_rdata(host_rdata), .upload_enable(upload_enable),
  .patch_version(patch_version), .param_req_pulse(param_req_pulse),
  .param_req_dir(param_req_dir), .param_req_page(param_req_page),
  .param_ack_zero(param_ack_zero), .patch_wr_valid(patch_wr_valid),
  .patch_wr_data(patch_wr_data), .cpu_reset_pulse(cpu_reset_pulse));

// ---- hpu_regs_test.sv ----
// self-checking bench for the host register bank
// assumes hpu_regs with default id parameters
module hpu_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset_n = 0, host_wr = 0, host_rd = 0;
  logic upload_enable = 0, param_ack_zero = 1, patch_wr_valid;
  logic [7:0] host_addr = 0, host_wdata = 0, host_rdata, core_rdata, a;
  logic [3:0] core_addr = 0;
  logic [15:0] patch_version = 16'h1234, patch_wr_addr;
  logic [6:0] param_req_page;
  logic param_req_pulse, param_req_dir, cpu_reset_pulse;
  logic [31:0] crc = 32'hffff_ffff;
  int n_mismatch = 0, n_tests = 0;
  wire [7:0] patch_wr_data_w;
  hpu_regs dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .host_addr(host_addr), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rd(host_rd), .host_rdata(host_rdata),
    .upload_enable(upload_enable), .patch_version(patch_version),
    .core_addr(core_addr), .core_rdata(core_rdata),
    .param_req_pulse(param_req_pulse), .param_req_dir(param_req_dir),
    .param_req_page(param_req_page), .param_ack_zero(param_ack_zero),
    .patch_wr_valid(patch_wr_valid), .patch_wr_addr(patch_wr_addr),
    .patch_wr_data(patch_wr_data_w), .cpu_reset_pulse(cpu_reset_pulse));
  hpu_core_mdl mdl_u (.sys_clk(sys_clk), .patch_wr_valid(patch_wr_valid),
    .patch_wr_addr(patch_wr_addr), .patch_wr_data(patch_wr_data_w));
  // ====================
  // clock and tasks
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge sys_clk) {host_addr, host_wdata, host_wr} = {ad, d, 1'b1};
    @(negedge sys_clk) host_wr = 0;
  endtask
  task rd(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge sys_clk) {host_addr, host_rd} = {ad, 1'b1};
    @(negedge sys_clk) host_rd = 0;
    chk(host_rdata, exp);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // reflected crc over one streamed byte
  task crc_byte(input logic [7:0] b);
    crc = crc ^ {24'h0, b};
    repeat (8) crc = crc[0] ? (crc >> 1) ^ 32'hedb8_8320 : crc >> 1;
  endtask
  initial begin
    #200000 n_mismatch++;
    test_done;
  end
  // ====================
  // test sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1;
    rd(8'h94, 0);
    rd(8'h97, 0);
    rd(8'h70, 0);
    rd(8'h72, 8'h12);
    rd(8'h73, 8'h34);
    rd(8'h91, 8'h0a);
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h00);
    wr(8'h91, 8'hff);
    rd(8'h91, 8'h0a);
    wr(8'h98, 8'hff);
    rd(8'h98, 8'h00);
    wr(8'h90, 8'hff);
    rd(8'h90, 8'h5a);
    $display("test ids done");
    for (int i = 0; i < 13; i++) begin
      a = i < 6 ? 8'h56 + i : 8'h5f + i;
      wr(a, 8'ha0 + i);
      rd(a, 8'ha0 + i);
      core_addr = i;
      @(negedge sys_clk) chk(core_rdata, 8'ha0 + i);
    end
    for (int i = 0; i < 8; i++) wr(8'h5c + i, 8'h30 + i);
    for (int i = 0; i < 8; i++) rd(8'h5c + i, 8'h30 + i);
    $display("test areas done");
    for (int p = 1; p < 4; p++) begin
      wr(8'h64, {p[0], p[6:0]});
      chk(param_req_pulse, 1);
      chk({param_req_dir, param_req_page}, {p[0], p[6:0]});
    end
    param_ack_zero = 0;
    wr(8'h64, 8'h82);
    chk(param_req_pulse, 0);
    param_ack_zero = 1;
    $display("test request done");
    wr(8'h94, 8'h12);
    wr(8'h95, 8'h34);
    rd(8'h94, 8'h12);
    rd(8'h95, 8'h34);
    wr(8'h94, 0);
    wr(8'h95, 0);
    upload_enable = 1;
    // file word 11223344 goes out byte swapped
    for (int i = 0; i < 4; i++) begin
      wr(8'h96, 8'h44 - 8'h11 * i);
      crc_byte(8'h44 - 8'h11 * i);
      @(negedge sys_clk) chk(mdl_u.last_addr, i);
    end
    crc = ~crc;
    upload_enable = 0;
    wr(8'h96, 8'h55);
    chk(mdl_u.n_wr, 4);
    rd(8'h95, 8'h04);
    for (int i = 0; i < 4; i++) rd(8'h97 + i, crc[8*i+:8]);
    $display("test upload done");
    wr(8'h9b, 8'h01);
    chk(cpu_reset_pulse, 1);
    @(negedge sys_clk) chk(cpu_reset_pulse, 0);
    rd(8'h9b, 0);
    $display("test restart done");
    test_done;
  end
endmodule
